// *** mtc_pkg.sv ***
// Package for the measurement trigger controller: command codes, sources, states, APB map.
// Assumes a single 100 MHz clock and an APB master driving 32-bit aligned accesses.
package mtc_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned SETTLE_NS = 2000;
  localparam int unsigned SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned NCH = 2;

  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_RESP = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;

  localparam logic [15:0] ERR_TRIG_IGN = 16'hFF2D; // -211
  localparam logic [15:0] ERR_INIT_IGN = 16'hFF2B; // -213
  localparam logic [15:0] ERR_CONFLICT = 16'hFF23; // -221
  localparam logic [15:0] SPEED_CONFLICT = 16'h00C8; // 200

  typedef enum logic [2:0] {
    SRC_ALWAYS = 3'd0, SRC_BUS = 3'd1, SRC_HOLD = 3'd2,
    SRC_EXT = 3'd3, SRC_INTERNAL_LEVEL_SOURCE_ONE = 3'd4, SRC_INTERNAL_LEVEL_SOURCE_TWO = 3'd5
  } mtc_src_e;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_SET_SRC = 4'h1, OP_SET_DLY = 4'h2, OP_FORCE = 4'h3,
    OP_INIT = 4'h4, OP_ABORT = 4'h5, OP_SET_CONT = 4'h6, OP_RESET = 4'h7,
    OP_Q_SRC = 4'h8, OP_Q_DLY = 4'h9, OP_BUS_TRG = 4'hA, OP_MEAS_CONF = 4'hB,
    OP_LOCAL = 4'hC
  } mtc_op_e;

  // Gray along idle -> wait -> settle -> measure.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_WAIT = 2'b01, ST_SETTLE = 2'b11, ST_MEAS = 2'b10
  } mtc_state_e;

  typedef struct packed {
    logic [2:0] arg;
    logic [0:0] chan;
    logic [3:0] op;
  } mtc_cmd_s;
endpackage

// *** mtc_trigger_ctrl.sv ***
// Measurement trigger controller: per-channel source, settle delay and trigger state.
// Assumes APB for commands, a synchronous external trigger, and a measure-done pulse.
`timescale 1ns/1ps
`default_nettype none
module mtc_trigger_ctrl #(
  parameter int unsigned SETTLE_CYCLES = mtc_pkg::SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic ext_trig_i,
  input wire logic [1:0] meas_done_i,
  output logic [1:0] meas_start_o,
  output logic [1:0] meas_store_o
);
  // CTRL register: [15:0] sensing_rate_setting, [16] detector_function averaging,
  // [17] channel 1 slaved to channel 0.
  logic [15:0] speed_q;
  logic avg_q;
  logic slaved_q;
  logic [2:0] src_q [mtc_pkg::NCH];
  logic dly_q [mtc_pkg::NCH];
  logic cont_q [mtc_pkg::NCH];
  mtc_pkg::mtc_state_e st_q [mtc_pkg::NCH];
  logic [15:0] cnt_q [mtc_pkg::NCH];
  logic forced_q [mtc_pkg::NCH];
  logic [15:0] err_q;
  logic [2:0] resp_q;
  logic ext_q;
  logic [1:0] start_q;
  logic [1:0] store_q;

  logic acc;
  logic cmd_wr;
  mtc_pkg::mtc_cmd_s cmd;
  logic ext_rise;
  assign acc = psel_i && penable_i;
  assign cmd = pwdata_i[7:0];
  assign cmd_wr = acc && pwrite_i && (paddr_i == mtc_pkg::OFS_CMD);
  assign ext_rise = ext_trig_i && !ext_q;

  function automatic logic is_level_src(input logic [2:0] s);
    is_level_src = (s == 3'(mtc_pkg::SRC_EXT)) || (s == 3'(mtc_pkg::SRC_INTERNAL_LEVEL_SOURCE_ONE)) ||
      (s == 3'(mtc_pkg::SRC_INTERNAL_LEVEL_SOURCE_TWO));
  endfunction

  // Settings conflicts checked before a source change is accepted.
  logic src_conflict;
  always_comb begin
    src_conflict = 1'b0;
    if (cmd_wr && mtc_pkg::mtc_op_e'(cmd.op) == mtc_pkg::OP_SET_SRC) begin
      if (cmd.chan == 1'b0 && slaved_q && !is_level_src(cmd.arg)) begin
        src_conflict = 1'b1;
      end
      if (is_level_src(cmd.arg) && speed_q == mtc_pkg::SPEED_CONFLICT) begin
        src_conflict = 1'b1;
      end
      if (is_level_src(cmd.arg) && avg_q) begin
        src_conflict = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= ext_trig_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      speed_q <= 16'h0000;
      avg_q <= 1'b0;
      slaved_q <= 1'b0;
    end else if (acc && pwrite_i && paddr_i == mtc_pkg::OFS_CTRL) begin
      speed_q <= pwdata_i[15:0];
      avg_q <= pwdata_i[16];
      slaved_q <= pwdata_i[17];
    end
  end

  for (genvar c = 0; c < mtc_pkg::NCH; c++) begin : g_ch
    logic hit;
    logic trig;
    logic force_ok;
    mtc_pkg::mtc_op_e op;
    assign hit = cmd_wr && (cmd.chan == 1'(c));
    assign op = mtc_pkg::mtc_op_e'(cmd.op);
    assign force_ok = hit && op == mtc_pkg::OP_FORCE && st_q[c] == mtc_pkg::ST_WAIT;
    always_comb begin
      trig = 1'b0;
      case (mtc_pkg::mtc_src_e'(src_q[c]))
        // always-true triggers as soon as waiting
        mtc_pkg::SRC_ALWAYS: trig = 1'b1;
        mtc_pkg::SRC_BUS: trig = hit && op == mtc_pkg::OP_BUS_TRG;
        mtc_pkg::SRC_EXT: trig = ext_rise;
        mtc_pkg::SRC_HOLD: trig = 1'b0;
        default: trig = 1'b0;
      endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        src_q[c] <= 3'(mtc_pkg::SRC_ALWAYS);
        dly_q[c] <= 1'b1;
        cont_q[c] <= 1'b1;
      end else if (hit) begin
        case (op)
          mtc_pkg::OP_SET_SRC: if (!src_conflict) src_q[c] <= cmd.arg;
          mtc_pkg::OP_SET_DLY: dly_q[c] <= cmd.arg[0];
          mtc_pkg::OP_SET_CONT: cont_q[c] <= cmd.arg[0];
          mtc_pkg::OP_RESET: begin
            src_q[c] <= 3'(mtc_pkg::SRC_ALWAYS);
            dly_q[c] <= 1'b1;
            cont_q[c] <= 1'b0;
          end
          mtc_pkg::OP_MEAS_CONF: src_q[c] <= 3'(mtc_pkg::SRC_ALWAYS);
          mtc_pkg::OP_LOCAL: begin
            if (src_q[c] != 3'(mtc_pkg::SRC_EXT)) cont_q[c] <= 1'b1;
            src_q[c] <= 3'(mtc_pkg::SRC_ALWAYS);
          end
          default: ;
        endcase
      end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        st_q[c] <= mtc_pkg::ST_IDLE;
        cnt_q[c] <= 16'h0000;
        forced_q[c] <= 1'b0;
        start_q[c] <= 1'b0;
        store_q[c] <= 1'b0;
      end else begin
        start_q[c] <= 1'b0;
        store_q[c] <= 1'b0;
        case (st_q[c])
          mtc_pkg::ST_IDLE: begin
            if ((hit && op == mtc_pkg::OP_INIT) || cont_q[c]) begin
              st_q[c] <= mtc_pkg::ST_WAIT;
            end
          end
          mtc_pkg::ST_WAIT: begin
            if (hit && (op == mtc_pkg::OP_ABORT || op == mtc_pkg::OP_RESET)) begin
              st_q[c] <= mtc_pkg::ST_IDLE;
            end else if (force_ok) begin
              st_q[c] <= mtc_pkg::ST_MEAS;
              start_q[c] <= 1'b1;
              forced_q[c] <= 1'b1;
            end else if (trig && dly_q[c]) begin
              st_q[c] <= mtc_pkg::ST_SETTLE;
              cnt_q[c] <= 16'(SETTLE_CYCLES - 1);
            end else if (trig) begin
              st_q[c] <= mtc_pkg::ST_MEAS;
              start_q[c] <= 1'b1;
            end
          end
          mtc_pkg::ST_SETTLE: begin
            if (hit && (op == mtc_pkg::OP_ABORT || op == mtc_pkg::OP_RESET)) begin
              st_q[c] <= mtc_pkg::ST_IDLE;
            end else if (cnt_q[c] == 16'h0000) begin
              st_q[c] <= mtc_pkg::ST_MEAS;
              start_q[c] <= 1'b1;
            end else begin
              cnt_q[c] <= cnt_q[c] - 16'h0001;
            end
          end
          mtc_pkg::ST_MEAS: begin
            if (hit && (op == mtc_pkg::OP_ABORT || op == mtc_pkg::OP_RESET)) begin
              st_q[c] <= mtc_pkg::ST_IDLE;
            end else if (meas_done_i[c]) begin
              store_q[c] <= 1'b1;
              forced_q[c] <= 1'b0;
              st_q[c] <= cont_q[c] ? mtc_pkg::ST_WAIT : mtc_pkg::ST_IDLE;
            end
          end
          default: st_q[c] <= mtc_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Error register holds the last error code until software clears it by writing STAT.
  // A new error in the clearing cycle wins over the clear.
  logic [15:0] new_err;
  always_comb begin
    new_err = 16'h0000;
    if (cmd_wr) begin
      if (mtc_pkg::mtc_op_e'(cmd.op) == mtc_pkg::OP_FORCE &&
          st_q[cmd.chan] != mtc_pkg::ST_WAIT) begin
        new_err = mtc_pkg::ERR_TRIG_IGN;
      end
      if (mtc_pkg::mtc_op_e'(cmd.op) == mtc_pkg::OP_INIT &&
          (st_q[cmd.chan] != mtc_pkg::ST_IDLE || cont_q[cmd.chan])) begin
        new_err = mtc_pkg::ERR_INIT_IGN;
      end
      if (src_conflict) begin
        new_err = mtc_pkg::ERR_CONFLICT;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      err_q <= 16'h0000;
    end else if (new_err != 16'h0000) begin
      err_q <= new_err;
    end else if (acc && pwrite_i && paddr_i == mtc_pkg::OFS_STAT) begin
      err_q <= 16'h0000;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      resp_q <= 3'b000;
    end else if (cmd_wr) begin
      case (mtc_pkg::mtc_op_e'(cmd.op))
        mtc_pkg::OP_Q_SRC: resp_q <= src_q[cmd.chan];
        mtc_pkg::OP_Q_DLY: resp_q <= {2'b00, dly_q[cmd.chan]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !pready_o && !penable_i ? 1'b1 : 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      if (psel_i && !penable_i) begin
        case (paddr_i)
          mtc_pkg::OFS_CMD: prdata_o <= 32'h0000_0000;
          mtc_pkg::OFS_RESP: prdata_o <= {29'h0, resp_q};
          mtc_pkg::OFS_CTRL: prdata_o <= {14'h0, slaved_q, avg_q, speed_q};
          mtc_pkg::OFS_STAT: prdata_o <= {err_q, 12'h0, st_q[1], st_q[0]};
          default: pslverr_o <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meas_start_o <= 2'b00;
      meas_store_o <= 2'b00;
    end else begin
      meas_start_o <= start_q;
      meas_store_o <= store_q;
    end
  end
endmodule
`default_nettype wire

// *** mtc_trigger_ctrl_properties.sv ***
// Concurrent checks on the trigger controller's APB port and measurement pulses.
// Assumes it is bound to mtc_trigger_ctrl and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module mtc_trigger_ctrl_properties (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic ext_trig_i,
  input wire logic [1:0] meas_done_i,
  input wire logic [1:0] meas_start_o,
  input wire logic [1:0] meas_store_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence setup_s; psel_i && !penable_i; endsequence
  sequence access_s; psel_i && penable_i; endsequence
  logic hit;
  assign hit = psel_i && penable_i && pready_o;
  zero_wait_a: assert property (setup_s ##1 access_s |-> pready_o)
    else $error("ready missing in first access cycle");
  ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready held too long");
  ready_phase_a: assert property (pready_o |-> access_s) else $error("ready outside access");
  err_ready_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  err_zero_a: assert property (pslverr_o |-> prdata_o == 32'h0000_0000)
    else $error("error read data not zero");
  unmapped_err_a: assert property (hit && (paddr_i > 8'h0C || paddr_i[1:0] != 2'b00) |-> pslverr_o)
    else $error("unmapped address accepted");
  mapped_ok_a: assert property (hit && (paddr_i == 8'h08 || paddr_i == 8'h0C) |-> !pslverr_o)
    else $error("mapped address refused");
  start_pulse_a: assert property (|meas_start_o |=> (meas_start_o & $past(meas_start_o)) == 2'b00)
    else $error("start pulse longer than one cycle");
  store_zero_a: assert property (meas_done_i[0] |-> ##[0:2] meas_store_o[0])
    else $error("channel 0 result not stored");
  store_one_a: assert property (meas_done_i[1] |-> ##[0:2] meas_store_o[1])
    else $error("channel 1 result not stored");
endmodule
bind mtc_trigger_ctrl mtc_trigger_ctrl_properties mtc_trigger_ctrl_properties_inst (.clk_i,
  .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
  .pslverr_o, .ext_trig_i, .meas_done_i, .meas_start_o, .meas_store_o);
`default_nettype wire

// *** mtc_meas_model.sv ***
// Model of the measurement engine behind the controller: one done pulse per start.
// Assumes starts never overlap on a channel; channel 0 answers promptly, channel 1 slowly.
`timescale 1ns/1ps
`default_nettype none
module mtc_meas_model #(
  parameter int unsigned LAT0 = 3,
  parameter int unsigned LAT1 = 9
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [1:0] start_i,
  output logic [1:0] done_o
);
  int cnt [2];
  always @(posedge clk_i or negedge arst_n_i) begin
    for (int c = 0; c < 2; c++) begin
      if (!arst_n_i) begin
        cnt[c] <= 0;
        done_o[c] <= 1'b0;
      end else begin
        done_o[c] <= (cnt[c] == 1);
        if (start_i[c]) cnt[c] <= (c == 0) ? LAT0 : LAT1;
        else if (cnt[c] != 0) cnt[c] <= cnt[c] - 1;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench: commands over APB, latencies and pulse counts compared.
// Assumes the settle count is shortened to SC cycles for simulation.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int SC = 4;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic rear_panel_input_source = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, r;
  logic prdy, perr, er;
  logic [1:0] done, start, store;
  int n_errors = 0;
  int n_compared = 0;
  int ns [2] = '{0, 0};
  int k, l0, l1, lf;
  logic [31:0] cv [3] = '{32'h0000_00C8, 32'h0001_0000, 32'h0002_0000};
  logic [2:0] ca [3] = '{3'd3, 3'd4, 3'd1};
  logic cc [3] = '{1'b1, 1'b1, 1'b0};
  always #5 clk_i = ~clk_i;
  mtc_trigger_ctrl #(.SETTLE_CYCLES(SC)) mtc_trigger_ctrl_inst (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(prdy), .pslverr_o(perr),
    .ext_trig_i(rear_panel_input_source), .meas_done_i(done), .meas_start_o(start), .meas_store_o(store));
  mtc_meas_model mtc_meas_model_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .start_i(start),
    .done_o(done));
  always @(posedge clk_i) for (int c = 0; c < 2; c++) if (start[c] === 1'b1) ns[c]++;
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (prdy !== 1'b1 && n < 16);
    r = prdata;
    er = perr;
    chk("pready", 1, prdy);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic cmd(input logic [3:0] o, input logic c, input logic [2:0] a);
    apb(1'b1, mtc_pkg::OFS_CMD, {24'h00_0000, mtc_pkg::mtc_cmd_s'{a, c, o}});
  endtask
  task automatic q(input logic [3:0] o, input logic c, input logic [2:0] e, input string s);
    cmd(o, c, 3'd0);
    apb(1'b0, mtc_pkg::OFS_RESP, 0);
    chk(s, e, r[2:0]);
  endtask
  task automatic lat(input logic c, output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (start[c] !== 1'b1 && n < 64);
  endtask
  task automatic stat(input logic [1:0] e, input logic [15:0] x);
    apb(1'b0, mtc_pkg::OFS_STAT, 0);
    chk("state", e, r[1:0]);
    chk("error", x, r[31:16]);
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    print_verdict;
  end
  initial begin
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (40) @(posedge clk_i);
    chk("free run", 1, ns[0] > 2);
    q(mtc_pkg::OP_Q_SRC, 0, 0, "power-up source");
    q(mtc_pkg::OP_Q_DLY, 0, 1, "power-up delay");
    cmd(mtc_pkg::OP_SET_DLY, 0, 0);
    q(mtc_pkg::OP_Q_DLY, 0, 0, "delay off");
    cmd(mtc_pkg::OP_SET_SRC, 0, 2);
    q(mtc_pkg::OP_Q_SRC, 0, 2, "hold source");
    q(mtc_pkg::OP_Q_SRC, 1, 0, "other channel");
    cmd(mtc_pkg::OP_RESET, 0, 0);
    q(mtc_pkg::OP_Q_DLY, 0, 1, "reset delay");
    q(mtc_pkg::OP_Q_SRC, 0, 0, "reset source");
    $display("test defaults done");
    repeat (40) @(posedge clk_i);
    apb(1'b1, mtc_pkg::OFS_STAT, 0);
    cmd(mtc_pkg::OP_SET_SRC, 0, 2);
    stat(2'd0, 16'h0000);
    k = ns[0];
    cmd(mtc_pkg::OP_FORCE, 0, 0);
    repeat (10) @(posedge clk_i);
    stat(2'd0, mtc_pkg::ERR_TRIG_IGN);
    cmd(mtc_pkg::OP_INIT, 0, 0);
    stat(2'd1, mtc_pkg::ERR_TRIG_IGN);
    cmd(mtc_pkg::OP_BUS_TRG, 0, 0);
    rear_panel_input_source <= 1'b1;
    @(posedge clk_i);
    rear_panel_input_source <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk("hold starts", k, ns[0]);
    cmd(mtc_pkg::OP_FORCE, 0, 0);
    lat(0, lf);
    $display("test forced done");
    repeat (40) @(posedge clk_i);
    cmd(mtc_pkg::OP_SET_SRC, 0, 1);
    cmd(mtc_pkg::OP_SET_DLY, 0, 0);
    cmd(mtc_pkg::OP_INIT, 0, 0);
    cmd(mtc_pkg::OP_BUS_TRG, 0, 0);
    lat(0, l0);
    repeat (40) @(posedge clk_i);
    stat(2'd0, mtc_pkg::ERR_TRIG_IGN);
    cmd(mtc_pkg::OP_SET_DLY, 0, 1);
    cmd(mtc_pkg::OP_INIT, 0, 0);
    cmd(mtc_pkg::OP_BUS_TRG, 0, 0);
    lat(0, l1);
    chk("settle latency", l0 + SC, l1);
    chk("forced latency", l0, lf);
    $display("test bus done");
    repeat (40) @(posedge clk_i);
    cmd(mtc_pkg::OP_SET_SRC, 0, 3);
    cmd(mtc_pkg::OP_INIT, 0, 0);
    k = ns[0];
    rear_panel_input_source <= 1'b1;
    @(posedge clk_i);
    rear_panel_input_source <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk("external start", k + 1, ns[0]);
    cmd(mtc_pkg::OP_MEAS_CONF, 0, 0);
    q(mtc_pkg::OP_Q_SRC, 0, 0, "measure source");
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, mtc_pkg::OFS_CTRL, cv[i]);
      apb(1'b1, mtc_pkg::OFS_STAT, 0);
      cmd(mtc_pkg::OP_SET_SRC, cc[i], ca[i]);
      apb(1'b0, mtc_pkg::OFS_STAT, 0);
      chk("conflict", mtc_pkg::ERR_CONFLICT, r[31:16]);
      q(mtc_pkg::OP_Q_SRC, cc[i], 0, "kept source");
    end
    apb(1'b1, mtc_pkg::OFS_CTRL, 0);
    apb(1'b0, 8'h10, 0);
    chk("unmapped", 1, er);
    $display("test conflicts done");
    repeat (40) @(posedge clk_i);
    k = ns[0];
    cmd(mtc_pkg::OP_INIT, 0, 0);
    repeat (40) @(posedge clk_i);
    chk("single shot", k + 1, ns[0]);
    cmd(mtc_pkg::OP_SET_CONT, 0, 1);
    // One free-run cycle takes about eleven clocks with the short settle count.
    repeat (60) @(posedge clk_i);
    chk("rearm run", 1, ns[0] > k + 3);
    cmd(mtc_pkg::OP_SET_SRC, 0, 2);
    cmd(mtc_pkg::OP_LOCAL, 0, 0);
    q(mtc_pkg::OP_Q_SRC, 0, 0, "local source");
    $display("test always done");
    print_verdict;
  end
endmodule
`default_nettype wire
